// ===== verilog/i2cs_defs.vh
// constants for the i2c target receive and addressing block
`ifndef I2CS_DEFS_VH
`define I2CS_DEFS_VH

// ----------------------------------------------------------------
// main state machine, one-hot
// ----------------------------------------------------------------
`define I2CS_ST_IDLE 5'h01
`define I2CS_ST_SHIFT 5'h02
`define I2CS_ST_ACK 5'h04
`define I2CS_ST_SEND 5'h08
`define I2CS_ST_MACK 5'h10

// ----------------------------------------------------------------
// byte phase within a frame, one-hot
// ----------------------------------------------------------------
`define I2CS_PH_FIRST 4'h1
`define I2CS_PH_SECOND 4'h2
`define I2CS_PH_DATA 4'h4
`define I2CS_PH_RESTART 4'h8

// ----------------------------------------------------------------
// counts, patterns, reset values
// ----------------------------------------------------------------
`define I2CS_BITS_PER_BYTE 4'h8
`define I2CS_LAST_TX_BIT 4'h7
`define I2CS_TENBIT_PATTERN 5'h1E
`define I2CS_OWN_ADDR_RST 8'h00
`define I2CS_SYNC_RST 2'h3
`define I2CS_FIFO_WIDTH 8
`define I2CS_FIFO_DEPTH 16
`define I2CS_FIFO_AW 4

// ----------------------------------------------------------------
// status byte field positions
// ----------------------------------------------------------------
`define I2CS_STAT_BF_BIT 0
`define I2CS_STAT_UA_BIT 1
`define I2CS_STAT_RW_BIT 2

`endif

// ===== verilog/i2cs_sync.v
// two-flop synchroniser for pin inputs
`default_nettype none

module i2cs_sync #(
  parameter WIDTH = 2,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // data
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
    end
  end

  assign syncOut = sync_reg;

endmodule

`default_nettype wire

// ===== verilog/i2cs_fifo.v
// flip-flop FIFO with valid/ready on both sides
`default_nettype none

module i2cs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_reg;
  reg [AW-1:0] rdPtr_reg;
  reg [AW:0] count_reg;
  wire doWrite;
  wire doRead;

  assign inReady = (count_reg != DEPTH[AW:0]);
  assign outValid = (count_reg != {(AW+1){1'b0}});
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign outData = mem[rdPtr_reg];

  always @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_reg <= count_reg + 1'b1;
      end else if (doRead && !doWrite) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ===== verilog/i2cs_slave.v
// i2c target: address match, acknowledge, receive buffering and flags
`include "i2cs_defs.vh"
`default_nettype none

module i2cs_slave (
  // clock and reset
  input wire clk,
  input wire rst,
  // i2c pins, enables low while driving
  input wire sclIn,
  output wire sclOut,
  output wire sclOeN,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOeN,
  // control
  input wire enable,
  input wire tenBitMode,
  input wire addrWrEn,
  input wire [7:0] addrWrData,
  input wire irqClear,
  input wire overflowClear,
  input wire [7:0] txByte,
  // status
  output wire [7:0] ownAddress,
  output wire bufferFullFlag,
  output wire overflowFlag,
  output wire irqFlag,
  output wire addressUpdateFlag,
  output wire readWriteFlag,
  output wire [7:0] serialStatus,
  // received byte stream
  output wire [7:0] rxData,
  output wire rxValid,
  input wire rxReady
);

  // ----------------------------------------------------------------
  // pin sampling and bus events
  // ----------------------------------------------------------------
  wire [1:0] pinSync;
  wire sclS = pinSync[1];
  wire sdaS = pinSync[0];
  reg sclD_reg;
  reg sdaD_reg;

  i2cs_sync #(
    .WIDTH(2),
    .RST_VAL(`I2CS_SYNC_RST)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .asyncIn({sclIn, sdaIn}),
    .syncOut(pinSync)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sclD_reg <= 1'b1;
      sdaD_reg <= 1'b1;
    end else begin
      sclD_reg <= sclS;
      sdaD_reg <= sdaS;
    end
  end

  wire sclRise = sclS && !sclD_reg;
  wire sclFall = !sclS && sclD_reg;
  wire startCond = enable && sclS && sclD_reg && sdaD_reg && !sdaS;
  wire stopCond = sclS && sclD_reg && !sdaD_reg && sdaS;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [4:0] state_reg;
  reg [3:0] phase_reg;
  reg [3:0] bitCnt_reg;
  reg [7:0] serialShift_reg;
  reg [7:0] rxBuf_reg;
  reg [7:0] ownAddr_reg;
  reg [7:0] txShift_reg;
  reg bf_reg;
  reg ov_reg;
  reg irq_reg;
  reg ua_reg;
  reg rw_reg;
  reg ackOk_reg;
  reg isAddr_reg;
  reg goSend_reg;
  reg stretch_reg;
  reg matched10_reg;
  reg sdaDrive_reg;
  reg masterAck_reg;

  // ----------------------------------------------------------------
  // address decode at the end of the eighth bit
  // ----------------------------------------------------------------
  wire inShift = (state_reg == `I2CS_ST_SHIFT);
  wire byteDone = inShift && sclFall && (bitCnt_reg == `I2CS_BITS_PER_BYTE);
  wire phFirst = (phase_reg == `I2CS_PH_FIRST);
  wire phSecond = (phase_reg == `I2CS_PH_SECOND);
  wire phData = (phase_reg == `I2CS_PH_DATA);
  wire phRestart = (phase_reg == `I2CS_PH_RESTART);
  wire eqHigh7 = (serialShift_reg[7:1] == ownAddr_reg[7:1]);
  wire tenHdr = (serialShift_reg[7:3] == `I2CS_TENBIT_PATTERN);
  wire dirRead = serialShift_reg[0];
  // a 10-bit header must carry a write bit to be followed by the low byte
  wire matchNow = phData ||
    (phFirst && (tenBitMode ? (tenHdr && eqHigh7 && !dirRead) : eqHigh7)) ||
    (phSecond && (serialShift_reg == ownAddr_reg)) ||
    (phRestart && tenHdr && eqHigh7);

  wire accept = byteDone && matchNow;
  // only address bytes of a fresh 10-bit write ask software for a new address
  wire needUa = tenBitMode && (phFirst || phSecond || (phRestart && !dirRead));
  wire sendAfter = !phData && !phSecond && dirRead && (!tenBitMode || phRestart);
  wire toSecond = ((phFirst && tenBitMode) || phRestart) && !dirRead;

  // ----------------------------------------------------------------
  // flag set and clear terms, a set always wins over a clear
  // ----------------------------------------------------------------
  wire bfSet = accept && !bf_reg;
  wire ovSet = accept && bf_reg;
  wire ackFall = (state_reg == `I2CS_ST_ACK) && sclFall;
  wire mackFall = (state_reg == `I2CS_ST_MACK) && sclFall;
  wire irqSet = (ackFall && (ackOk_reg || !isAddr_reg)) || mackFall;
  wire fifoInReady;
  wire bufTaken = bf_reg && fifoInReady;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bf_reg <= 1'b0;
      ov_reg <= 1'b0;
      irq_reg <= 1'b0;
      ua_reg <= 1'b0;
      rw_reg <= 1'b0;
      rxBuf_reg <= 8'h00;
      ownAddr_reg <= `I2CS_OWN_ADDR_RST;
    end else begin
      if (bfSet) begin
        rxBuf_reg <= serialShift_reg;
        bf_reg <= 1'b1;
      end else if (bufTaken) begin
        bf_reg <= 1'b0;
      end
      if (ovSet) begin
        ov_reg <= 1'b1;
      end else if (overflowClear) begin
        ov_reg <= 1'b0;
      end
      if (irqSet) begin
        irq_reg <= 1'b1;
      end else if (irqClear) begin
        irq_reg <= 1'b0;
      end
      if (accept && needUa) begin
        ua_reg <= 1'b1;
      end else if (addrWrEn) begin
        ua_reg <= 1'b0;
      end
      if (accept && (phFirst || phRestart)) begin
        rw_reg <= dirRead;
      end
      if (addrWrEn) begin
        ownAddr_reg <= addrWrData;
      end
    end
  end

  // ----------------------------------------------------------------
  // bit engine
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= `I2CS_ST_IDLE;
      phase_reg <= `I2CS_PH_FIRST;
      bitCnt_reg <= 4'h0;
      serialShift_reg <= 8'h00;
      txShift_reg <= 8'h00;
      ackOk_reg <= 1'b0;
      isAddr_reg <= 1'b0;
      goSend_reg <= 1'b0;
      stretch_reg <= 1'b0;
      matched10_reg <= 1'b0;
      sdaDrive_reg <= 1'b0;
      masterAck_reg <= 1'b0;
    end else if (!enable) begin
      state_reg <= `I2CS_ST_IDLE;
      stretch_reg <= 1'b0;
      matched10_reg <= 1'b0;
      sdaDrive_reg <= 1'b0;
    end else if (startCond) begin
      state_reg <= `I2CS_ST_SHIFT;
      bitCnt_reg <= 4'h0;
      sdaDrive_reg <= 1'b0;
      phase_reg <= (tenBitMode && matched10_reg) ? `I2CS_PH_RESTART : `I2CS_PH_FIRST;
    end else if (stopCond) begin
      state_reg <= `I2CS_ST_IDLE;
      matched10_reg <= 1'b0;
      sdaDrive_reg <= 1'b0;
    end else begin
      if (addrWrEn) begin
        stretch_reg <= 1'b0;
      end
      case (state_reg)
        `I2CS_ST_IDLE: begin
          sdaDrive_reg <= 1'b0;
        end
        `I2CS_ST_SHIFT: begin
          if (sclRise && bitCnt_reg != `I2CS_BITS_PER_BYTE) begin
            serialShift_reg <= {serialShift_reg[6:0], sdaS};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end else if (byteDone) begin
            if (matchNow) begin
              state_reg <= `I2CS_ST_ACK;
              ackOk_reg <= !bf_reg && !ov_reg;
              sdaDrive_reg <= !bf_reg && !ov_reg;
              isAddr_reg <= !phData;
              goSend_reg <= sendAfter;
              matched10_reg <= matched10_reg || phSecond;
              phase_reg <= toSecond ? `I2CS_PH_SECOND : `I2CS_PH_DATA;
            end else begin
              state_reg <= `I2CS_ST_IDLE;
            end
          end
        end
        `I2CS_ST_ACK: begin
          if (sclFall) begin
            // low held for the whole ninth clock, released only now
            sdaDrive_reg <= 1'b0;
            // an address write in this very cycle has already released the line
            stretch_reg <= ua_reg && !addrWrEn;
            bitCnt_reg <= 4'h0;
            if (isAddr_reg && !ackOk_reg) begin
              state_reg <= `I2CS_ST_IDLE;
            end else if (goSend_reg) begin
              state_reg <= `I2CS_ST_SEND;
              txShift_reg <= txByte;
              sdaDrive_reg <= !txByte[7];
            end else begin
              state_reg <= `I2CS_ST_SHIFT;
            end
          end
        end
        `I2CS_ST_SEND: begin
          if (sclFall) begin
            if (bitCnt_reg == `I2CS_LAST_TX_BIT) begin
              state_reg <= `I2CS_ST_MACK;
              sdaDrive_reg <= 1'b0;
            end else begin
              txShift_reg <= {txShift_reg[6:0], 1'b0};
              sdaDrive_reg <= !txShift_reg[6];
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end
          end
        end
        `I2CS_ST_MACK: begin
          if (sclRise) begin
            masterAck_reg <= !sdaS;
          end else if (sclFall) begin
            bitCnt_reg <= 4'h0;
            if (masterAck_reg) begin
              state_reg <= `I2CS_ST_SEND;
              txShift_reg <= txByte;
              sdaDrive_reg <= !txByte[7];
            end else begin
              state_reg <= `I2CS_ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= `I2CS_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive stream: the FIFO taking the buffer counts as a read
  // ----------------------------------------------------------------
  // a full FIFO leaves buffer-full standing, so the next byte is refused
  i2cs_fifo #(
    .WIDTH(`I2CS_FIFO_WIDTH),
    .DEPTH(`I2CS_FIFO_DEPTH),
    .AW(`I2CS_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(bf_reg),
    .inReady(fifoInReady),
    .inData(rxBuf_reg),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxData)
  );

  // ----------------------------------------------------------------
  // outputs, open drain: only ever pulls low
  // ----------------------------------------------------------------
  assign sclOut = 1'b0;
  assign sclOeN = !stretch_reg;
  assign sdaOut = 1'b0;
  assign sdaOeN = !sdaDrive_reg;

  assign ownAddress = ownAddr_reg;
  assign bufferFullFlag = bf_reg;
  assign overflowFlag = ov_reg;
  assign irqFlag = irq_reg;
  assign addressUpdateFlag = ua_reg;
  assign readWriteFlag = rw_reg;
  assign serialStatus[`I2CS_STAT_BF_BIT] = bf_reg;
  assign serialStatus[`I2CS_STAT_UA_BIT] = ua_reg;
  assign serialStatus[`I2CS_STAT_RW_BIT] = rw_reg;
  assign serialStatus[7:3] = 5'h00;

endmodule

`default_nettype wire

// ===== testbench/i2cs_slave_properties.sv
// assertions on the ports of the i2c target block
`default_nettype none
module i2cs_slave_properties (
  // clock and reset
  input wire clk,
  input wire rst,
  // pins and control
  input wire sclIn,
  input wire sclOeN,
  input wire sdaOeN,
  input wire enable,
  input wire addrWrEn,
  input wire [7:0] addrWrData,
  input wire irqClear,
  input wire overflowClear,
  // status
  input wire [7:0] ownAddress,
  input wire bufferFullFlag,
  input wire overflowFlag,
  input wire irqFlag,
  input wire addressUpdateFlag,
  input wire readWriteFlag,
  input wire [7:0] serialStatus
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ------
  // properties
  // ------
  idle_release_a: assert property (!enable |=> sclOeN && sdaOeN)
    else $error("pins held while disabled");
  irq_sticky_a: assert property (irqFlag && !irqClear |=> irqFlag)
    else $error("irq flag dropped without clear");
  ovf_sticky_a: assert property (overflowFlag && !overflowClear |=> overflowFlag)
    else $error("overflow flag dropped without clear");
  ack_blocked_a: assert property ($fell(sdaOeN) && !readWriteFlag |->
    !$past(bufferFullFlag) && !$past(overflowFlag))
    else $error("ack given with full or overflow set");
  ack_loads_a: assert property ($fell(sdaOeN) && !readWriteFlag |-> bufferFullFlag)
    else $error("ack without buffer load");
  ack_irq_a: assert property ($rose(sdaOeN) && !readWriteFlag |-> irqFlag)
    else $error("ack end without irq flag");
  ack_span_a: assert property ($rose(sdaOeN) && !readWriteFlag |->
    !sclIn && !$past(sdaOeN, 8))
    else $error("ack too short or released with scl high");
  stretch_cause_a: assert property (!sclOeN |-> addressUpdateFlag)
    else $error("scl held without update flag");
  addr_write_a: assert property (addrWrEn |=> sclOeN && !addressUpdateFlag &&
    ownAddress == $past(addrWrData))
    else $error("address write did not release");
  status_pack_a: assert property (serialStatus ==
    {5'h00, readWriteFlag, addressUpdateFlag, bufferFullFlag})
    else $error("status byte layout wrong");
  cover property ($fell(sclOeN));
  cover property ($rose(overflowFlag));
  cover property ($rose(sdaOeN) && !readWriteFlag);
endmodule
bind i2cs_slave i2cs_slave_properties i_prop (.clk, .rst, .sclIn, .sclOeN, .sdaOeN,
  .enable, .addrWrEn, .addrWrData, .irqClear, .overflowClear, .ownAddress,
  .bufferFullFlag, .overflowFlag, .irqFlag, .addressUpdateFlag, .readWriteFlag,
  .serialStatus);
`default_nettype wire

// ===== testbench/i2cs_master_model.sv
// i2c bus controller model for the target's pins
`default_nettype none
module i2cs_master_model (
  // bus levels, pull-ups included
  input wire logic scl,
  input wire logic sda,
  // open-drain drives, 0 pulls low
  output logic sclDrv,
  output logic sdaDrv
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  // one 160 ns bit; waits while the target stretches scl
  task automatic pulse(input logic b, output logic seen);
    sdaDrv = b;
    #40;
    sclDrv = 1'b1;
    wait (scl === 1'b1);
    #40;
    seen = sda;
    #40;
    sclDrv = 1'b0;
    #40;
  endtask
  // odd offset keeps the link out of phase with clk
  task automatic start;
    #1.3;
    sdaDrv = 1'b1;
    sclDrv = 1'b1;
    #80;
    sdaDrv = 1'b0;
    #80;
    sclDrv = 1'b0;
    #40;
  endtask
  task automatic stop;
    sdaDrv = 1'b0;
    #40;
    sclDrv = 1'b1;
    #80;
    sdaDrv = 1'b1;
    #80;
  endtask
  task automatic wrByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(b[i], s);
    pulse(1'b1, s);
    ack = !s;
  endtask
  // reads one byte and refuses it, ending the transmit
  task automatic rdByte(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, s);
      b[i] = s;
    end
    pulse(1'b1, s);
  endtask
endmodule
`default_nettype wire

// ===== testbench/i2cs_slave_test.sv
// self-checking bench for the i2c target block
`include "i2cs_defs.vh"
`default_nettype none
module i2cs_slave_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic enable = 1'b0;
  logic tenBitMode = 1'b0;
  logic addrWrEn = 1'b0;
  logic irqClear = 1'b0;
  logic overflowClear = 1'b0;
  logic rxReady = 1'b0;
  logic holdRx = 1'b1;
  logic [7:0] addrWrData = 8'h00;
  logic [7:0] txByte = 8'h00;
  logic [7:0] own, hi, lo, rd;
  logic ack;
  wire sclOut, sclOeN, sdaOut, sdaOeN, sclDrv, sdaDrv;
  wire bufferFullFlag, overflowFlag, irqFlag, addressUpdateFlag, readWriteFlag, rxValid;
  wire [7:0] ownAddress, serialStatus, rxData;
  wire sclLine = sclDrv & (sclOeN | sclOut);
  wire sdaLine = sdaDrv & (sdaOeN | sdaOut);
  // irq, overflow, scl enable, sda enable, 0, rw, update, full
  wire [7:0] flags = {irqFlag, overflowFlag, sclOeN, sdaOeN, 1'b0, serialStatus[2:0]};
  int n_fail = 0;
  int n_tests = 0;
  logic [7:0] q[$];
  always #2 clk = ~clk;
  i2cs_slave i_dut (.clk, .rst, .sclIn(sclLine), .sclOut, .sclOeN, .sdaIn(sdaLine),
    .sdaOut, .sdaOeN, .enable, .tenBitMode, .addrWrEn, .addrWrData, .irqClear,
    .overflowClear, .txByte, .ownAddress, .bufferFullFlag, .overflowFlag, .irqFlag,
    .addressUpdateFlag, .readWriteFlag, .serialStatus, .rxData, .rxValid, .rxReady);
  i2cs_master_model i_mst (.scl(sclLine), .sda(sdaLine), .sclDrv, .sdaDrv);
  // ------
  // tasks
  // ------
  task automatic finish_test;
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // c is {overflowClear, irqClear, addrWrEn}
  task automatic ctl(input logic [2:0] c, input logic [7:0] a);
    @(negedge clk);
    addrWrData = a;
    {overflowClear, irqClear, addrWrEn} = c;
    @(negedge clk);
    {overflowClear, irqClear, addrWrEn} = 3'b000;
    @(negedge clk);
  endtask
  // queued first: the fifo may take the byte before the ack clock ends
  task automatic send(input logic [7:0] b, input logic expAck, input logic keep);
    if (keep)
      q.push_back(b);
    i_mst.wrByte(b, ack);
    check("ack", {7'h00, ack}, {7'h00, expAck});
  endtask
  task automatic drain;
    holdRx = 1'b0;
    for (int i = 0; i < 2000 && q.size() != 0; i++)
      @(negedge clk);
    check("drained", 8'(q.size()), 8'h00);
  endtask
  // far side stalls at random
  always @(negedge clk) begin
    rxReady = !holdRx && ($urandom % 2 == 1);
    if (rxReady && rxValid === 1'b1)
      check("rxData", rxData, q.pop_front());
  end
  initial begin
    #300000;
    n_fail++;
    finish_test();
  end
  // ------
  // scenarios
  // ------
  initial begin
    void'($urandom(62286));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("reset", flags, 8'h30);
    check("own", ownAddress, `I2CS_OWN_ADDR_RST);
    repeat (4) @(negedge clk);
    enable = 1'b1;
    own = 8'($urandom) & 8'hFE;
    ctl(3'b001, own);
    check("own", ownAddress, own);
    i_mst.start();
    send(own ^ 8'h04, 1'b0, 1'b0);
    i_mst.stop();
    check("miss", flags, 8'h30);
    i_mst.start();
    send(own, 1'b1, 1'b1);
    check("addr", flags, 8'hB0);
    for (int i = 0; i < 15; i++) begin
      ctl(3'b010, own);
      send(8'($urandom), 1'b1, 1'b1);
      check("data", flags, 8'hB0);
    end
    send(8'($urandom), 1'b1, 1'b1);
    check("full", flags, 8'hB1);
    send(8'($urandom), 1'b0, 1'b0);
    check("ovf", flags, 8'hF1);
    drain();
    check("read", flags, 8'hF0);
    send(8'($urandom), 1'b0, 1'b1);
    drain();
    check("ovfload", flags, 8'hF0);
    ctl(3'b110, own);
    send(8'($urandom), 1'b1, 1'b1);
    i_mst.stop();
    @(negedge clk);
    tenBitMode = 1'b1;
    hi = {`I2CS_TENBIT_PATTERN, 2'($urandom), 1'b0};
    lo = 8'($urandom);
    ctl(3'b011, hi);
    i_mst.start();
    send(hi, 1'b1, 1'b1);
    check("hdr", flags, 8'h92);
    ctl(3'b011, lo);
    check("upd", flags, 8'h30);
    send(lo, 1'b1, 1'b1);
    check("low", flags, 8'h92);
    ctl(3'b011, hi);
    send(8'($urandom), 1'b1, 1'b1);
    ctl(3'b010, hi);
    txByte = 8'($urandom) | 8'h80;
    i_mst.start();
    send(hi | 8'h01, 1'b1, 1'b1);
    check("restart", flags, 8'hB4);
    i_mst.rdByte(rd);
    check("tx", rd, txByte);
    i_mst.stop();
    drain();
    finish_test();
  end
endmodule
`default_nettype wire
